/* verilog/bhi_consts.svh */
// constants of the buffered host bus interface
`ifndef BHI_CONSTS_SVH
`define BHI_CONSTS_SVH
// Notes on behaviour
// (RULE1) six config bits relocate housekeeping ram area
// (RULE2) housekeeping area resets to words 0000h-03FFh
// (RULE3) ready output ends holdoff, cycle completes after
// (RULE4) fast access: holdoff at most one transfer
// (RULE5) host grants dma request within 10.5 us
// (RULE6) buffered mode never starts host bus cycles
// (RULE7) non-multiplexed host ties address latch high
// (RULE8) polarity strap sets read sense of direction
// (RULE9) wait-style strap 1 selects non-zero-wait interface
// (RULE10) host uses ready only in non-zero-wait mode
// (RULE11) host straps: buffered 0, wait 1, width 1
// (RULE12) transfer enable falls when strobed and ram free
// (RULE13) host may release select after transfer enable
// (RULE14) memory select high for ram, low register
// (RULE15) control inputs transparent, then latched after enable
// (RULE16) address transparent, latched next edge after enable
// (RULE17) host inputs resolved through internal sampling flops; here only select and strobe, and only when async_inputs is 1
// (RULE18) missed setup inserts one clock, host extends hold
// (RULE19) without fast access wait for all engine transfers

// ****************************************************************
// housekeeping relocation
// ****************************************************************
`define BHI_HK_RESET_BASE 6'h00
`define BHI_HK_OFF_BITS 10

// ****************************************************************
// local configuration register
// ****************************************************************
`define BHI_CFG_REG_ADDR 16'h0030
`define BHI_CFG_RELOC_MSB 5
`define BHI_CFG_FAST_BIT 6

// ****************************************************************
// timing
// ****************************************************************
`define BHI_CLK_MHZ 100
`define BHI_DMA_GRANT_NS 10500
`define BHI_DMA_GRANT_CYC ((`BHI_DMA_GRANT_NS * `BHI_CLK_MHZ) / 1000)
`define BHI_ADDR_HOLD_CYC 2'h1

`endif

/* verilog/bhi_pkg.sv */
// types and helper functions of the buffered host bus interface
package bhi_pkg;

  typedef logic [15:0] bhi_word_t;

  typedef enum logic [2:0] {
    DEV_IDLE  = 3'h0,
    DEV_CTL   = 3'h1,
    DEV_EXTRA = 3'h3,
    DEV_ADDR  = 3'h2,
    DEV_ACC   = 3'h6,
    DEV_READY = 3'h7
  } bhi_dev_state_t;

  typedef enum logic [1:0] {
    HST_IDLE = 2'h0,
    HST_STRB = 2'h1,
    HST_WAIT = 2'h3,
    HST_HOLD = 2'h2
  } bhi_host_state_t;

  // direction pin level for a read or write under a polarity strap
  function automatic logic bhi_dir_level(input logic is_read, input logic pol);
    return is_read ? pol : ~pol;
  endfunction

  // housekeeping word address from relocation base and offset
  function automatic logic [15:0] bhi_hk_map(input logic [5:0] base,
                                             input logic [9:0] off);
    return {base, off};
  endfunction

endpackage

/* verilog/bhi_if.sv */
// host bus pins between the host processor and the terminal
`timescale 1ns/10ps
interface bhi_if;
  logic                select_n;
  logic                data_strobe_in_n;
  logic                mem_reg;
  logic                rd_wr;
  logic                address_latch_in;
  bhi_pkg::bhi_word_t  addr;
  bhi_pkg::bhi_word_t  data_h;
  logic                data_h_oe;
  bhi_pkg::bhi_word_t  data_d;
  logic                data_d_oe;
  bhi_pkg::bhi_word_t  data_bus;
  logic                transfer_enable_out_n;
  logic                ready_handshake_out_n;
  logic                polarity_sel;
  logic                zero_wait;
  logic                transparent_buffered;
  logic                dma_request_or_width_pin;
  logic                trigger_sel;
  logic                msb_lsb;

  // resolved level of the shared data bus
  assign data_bus = data_d_oe ? data_d : (data_h_oe ? data_h : 16'hFFFF);

  modport dev (
    input  select_n, data_strobe_in_n, mem_reg, rd_wr, address_latch_in, addr,
    input  data_bus, polarity_sel, zero_wait, transparent_buffered,
    input  dma_request_or_width_pin, trigger_sel, msb_lsb,
    output data_d, data_d_oe, transfer_enable_out_n, ready_handshake_out_n
  );

  modport host (
    output select_n, data_strobe_in_n, mem_reg, rd_wr, address_latch_in, addr,
    output data_h, data_h_oe, polarity_sel, zero_wait, transparent_buffered,
    output dma_request_or_width_pin, trigger_sel, msb_lsb,
    input  data_bus, transfer_enable_out_n, ready_handshake_out_n
  );
endinterface

/* verilog/bhi_sampler.sv */
// sampling stage for the host strobe, with optional two-flop resolver
`timescale 1ns/10ps
module bhi_sampler (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // control
  input  wire logic async_en,
  // level in and out
  input  wire logic d_in,
  output logic      q_out
);
  logic s1_reg;
  logic s2_reg;

  // ****************************************************************
  // two flop resolver; first flop feeds only the second
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;  // [RULE17]
    end
  end

  assign q_out = async_en ? s2_reg : d_in;
endmodule

/* verilog/bhi_device.sv */
// terminal side of the 16-bit buffered non-zero-wait host interface
`timescale 1ns/10ps
`include "bhi_consts.svh"
module bhi_device (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  // host pins
  bhi_if.dev                       hif,
  // input resolution mode
  input  wire logic                async_inputs,
  // internal ram port
  output bhi_pkg::bhi_word_t       ram_addr,
  output bhi_pkg::bhi_word_t       ram_wdata,
  output logic                     ram_we,
  output logic                     ram_re,
  input  wire bhi_pkg::bhi_word_t  ram_rdata,
  // register file port
  output bhi_pkg::bhi_word_t       reg_addr,
  output bhi_pkg::bhi_word_t       reg_wdata,
  output logic                     reg_we,
  output logic                     reg_re,
  input  wire bhi_pkg::bhi_word_t  reg_rdata,
  // protocol engine arbitration
  input  wire logic                eng_busy,
  input  wire logic                eng_pending,
  output logic                     eng_hold,
  // housekeeping address map
  input  wire logic [9:0]          eng_hk_off,
  output bhi_pkg::bhi_word_t       hk_addr,
  // configuration view
  output logic [5:0]               reloc_base,
  output logic                     fast_access
);
  import bhi_pkg::*;

  bhi_dev_state_t  state_reg;
  bhi_dev_state_t  state_next;
  logic            req_raw;
  logic            req_s;
  logic            ram_free;
  logic            cur_mem;
  logic            cur_rd;
  logic            mem_q_reg;
  logic            rd_q_reg;
  logic            ctl_lat_reg;
  bhi_word_t       addr_q_reg;
  bhi_word_t       wdata_q_reg;
  bhi_word_t       dout_reg;
  logic            dout_oe_reg;
  logic            te_n_reg;
  logic            rdy_n_reg;
  logic [5:0]      reloc_reg;
  logic            fast_reg;
  bhi_word_t       hk_addr_reg;
  logic            is_cfg;
  logic            addr_edge;
  logic            grant;

  // ****************************************************************
  // strobe sampling
  // ****************************************************************
  assign req_raw = ~hif.select_n & ~hif.data_strobe_in_n;

  bhi_sampler u_sampler (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_en (async_inputs),
    .d_in     (req_raw),
    .q_out    (req_s)
  );

  // ****************************************************************
  // ram arbitration
  // ****************************************************************
  // fast mode waits only for the transfer in flight
  assign ram_free = fast_reg ? ~eng_busy : (~eng_busy & ~eng_pending);  // [RULE4] [RULE19]
  assign grant    = (state_reg == DEV_IDLE) & req_s & ram_free;  // [RULE12]

  // engine held off for the whole host cycle, and during a fast wait
  assign eng_hold = (state_reg != DEV_IDLE) | (fast_reg & req_s);  // [RULE4]

  // ****************************************************************
  // transparent control and address path
  // ****************************************************************
  assign cur_mem = ctl_lat_reg ? mem_q_reg : hif.mem_reg;  // [RULE15]
  assign cur_rd  = ctl_lat_reg ? rd_q_reg :
                   (hif.rd_wr == bhi_dir_level(1'b1, hif.polarity_sel));  // [RULE8]

  // address latches one clock later when inputs are resolved
  assign addr_edge = ((state_reg == DEV_CTL) & ~async_inputs) |
                     (state_reg == DEV_EXTRA);  // [RULE16] [RULE18]

  assign is_cfg = ~mem_q_reg & (addr_q_reg == `BHI_CFG_REG_ADDR);

  // ****************************************************************
  // state machine
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DEV_IDLE: begin
        if (grant) begin
          state_next = DEV_CTL;
        end
      end
      DEV_CTL: begin
        state_next = async_inputs ? DEV_EXTRA : DEV_ADDR;  // [RULE18]
      end
      DEV_EXTRA: begin
        state_next = DEV_ADDR;
      end
      DEV_ADDR: begin
        state_next = DEV_ACC;
      end
      DEV_ACC: begin
        state_next = DEV_READY;
      end
      DEV_READY: begin
        if (!req_s) begin
          state_next = DEV_IDLE;
        end
      end
      default: begin
        state_next = DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= DEV_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // transfer enable and ready handshake
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      te_n_reg <= 1'b1;
    end else if (grant) begin
      te_n_reg <= 1'b0;  // [RULE12]
    end else if ((state_reg == DEV_READY) && !req_s) begin
      te_n_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdy_n_reg <= 1'b1;
    end else if (state_reg == DEV_ACC) begin
      rdy_n_reg <= 1'b0;  // [RULE3]
    end else if ((state_reg == DEV_READY) && !req_s) begin
      rdy_n_reg <= 1'b1;
    end
  end

  assign hif.transfer_enable_out_n = te_n_reg;
  assign hif.ready_handshake_out_n = rdy_n_reg;

  // ****************************************************************
  // control and address latches
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mem_q_reg   <= 1'b0;
      rd_q_reg    <= 1'b0;
      ctl_lat_reg <= 1'b0;
    end else if (state_reg == DEV_CTL) begin
      mem_q_reg   <= cur_mem;  // [RULE14] [RULE15]
      rd_q_reg    <= cur_rd;
      ctl_lat_reg <= 1'b1;
    end else if (state_reg == DEV_IDLE) begin
      ctl_lat_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      addr_q_reg  <= 16'h0000;
      wdata_q_reg <= 16'h0000;
    end else if (addr_edge) begin
      addr_q_reg  <= hif.addr;  // [RULE16]
      wdata_q_reg <= hif.data_bus;
    end
  end

  // ****************************************************************
  // internal ram and register access; nothing goes out on the host bus
  // ****************************************************************
  assign ram_addr  = addr_q_reg;  // [RULE6]
  assign ram_wdata = wdata_q_reg;
  assign ram_we    = (state_reg == DEV_ADDR) & mem_q_reg & ~rd_q_reg;  // [RULE14]
  assign ram_re    = (state_reg == DEV_ADDR) & mem_q_reg & rd_q_reg;
  assign reg_addr  = addr_q_reg;
  assign reg_wdata = wdata_q_reg;
  assign reg_we    = (state_reg == DEV_ADDR) & ~mem_q_reg & ~rd_q_reg & ~is_cfg;
  assign reg_re    = (state_reg == DEV_ADDR) & ~mem_q_reg & rd_q_reg & ~is_cfg;

  // ****************************************************************
  // read data to the host
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dout_reg    <= 16'h0000;
      dout_oe_reg <= 1'b0;
    end else if ((state_reg == DEV_ACC) && rd_q_reg) begin
      dout_oe_reg <= 1'b1;
      if (mem_q_reg) begin
        dout_reg <= ram_rdata;
      end else if (is_cfg) begin
        dout_reg <= {9'h000, fast_reg, reloc_reg};
      end else begin
        dout_reg <= reg_rdata;
      end
    end else if ((state_reg == DEV_READY) && !req_s) begin
      dout_oe_reg <= 1'b0;
    end
  end

  assign hif.data_d    = dout_reg;
  assign hif.data_d_oe = dout_oe_reg;

  // ****************************************************************
  // configuration register: relocation base and fast access
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reloc_reg <= `BHI_HK_RESET_BASE;  // [RULE2]
      fast_reg  <= 1'b0;
    end else if ((state_reg == DEV_ADDR) && is_cfg && !rd_q_reg) begin
      reloc_reg <= wdata_q_reg[`BHI_CFG_RELOC_MSB:0];  // [RULE1]
      fast_reg  <= wdata_q_reg[`BHI_CFG_FAST_BIT];
    end
  end

  // ****************************************************************
  // housekeeping address relocation
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hk_addr_reg <= 16'h0000;
    end else begin
      hk_addr_reg <= bhi_hk_map(reloc_reg, eng_hk_off);  // [RULE1] [RULE2]
    end
  end

  assign hk_addr     = hk_addr_reg;
  assign reloc_base  = reloc_reg;
  assign fast_access = fast_reg;
endmodule

/* verilog/bhi_host.sv */
// host processor side of the 16-bit buffered non-zero-wait interface
`timescale 1ns/10ps
`include "bhi_consts.svh"
module bhi_host (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  // host pins
  bhi_if.host                      hif,
  // strap choice
  input  wire logic                pol_sel,
  // command
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire logic                cmd_read,
  input  wire logic                cmd_mem,
  input  wire bhi_pkg::bhi_word_t  cmd_addr,
  input  wire bhi_pkg::bhi_word_t  cmd_wdata,
  // response
  output logic                     rsp_valid,
  output bhi_pkg::bhi_word_t       rsp_rdata
);
  import bhi_pkg::*;

  bhi_host_state_t  state_reg;
  logic             sel_n_reg;
  logic             strb_n_reg;
  logic             mem_reg_q;
  logic             rd_reg;
  bhi_word_t        addr_reg;
  bhi_word_t        wdata_reg;
  logic             wr_oe_reg;
  logic             rsp_valid_reg;
  bhi_word_t        rdata_reg;
  logic             done;

  // ****************************************************************
  // straps and fixed pins
  // ****************************************************************
  assign hif.address_latch_in         = 1'b1;  // [RULE7]
  assign hif.zero_wait                = 1'b1;  // [RULE9]
  assign hif.transparent_buffered     = 1'b0;  // [RULE11]
  assign hif.dma_request_or_width_pin = 1'b1;  // [RULE11]
  assign hif.trigger_sel              = 1'b0;
  assign hif.msb_lsb                  = 1'b0;
  assign hif.polarity_sel             = pol_sel;

  // ready is honoured only in the non-zero-wait style
  assign done = ~hif.ready_handshake_out_n | ~hif.zero_wait;  // [RULE10]

  // ****************************************************************
  // bus cycle sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg     <= HST_IDLE;
      sel_n_reg     <= 1'b1;
      strb_n_reg    <= 1'b1;
      wr_oe_reg     <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rdata_reg     <= 16'h0000;
    end else begin
      rsp_valid_reg <= 1'b0;
      case (state_reg)
        HST_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            sel_n_reg  <= 1'b0;
            strb_n_reg <= 1'b0;
            wr_oe_reg  <= ~cmd_read;
            state_reg  <= HST_STRB;
          end
        end
        HST_STRB: begin
          if (!hif.transfer_enable_out_n) begin
            sel_n_reg <= 1'b1;  // [RULE13]
            state_reg <= HST_WAIT;
          end
        end
        HST_WAIT: begin
          if (done) begin
            strb_n_reg    <= 1'b1;  // [RULE3]
            wr_oe_reg     <= 1'b0;
            rdata_reg     <= hif.data_bus;
            rsp_valid_reg <= 1'b1;
            state_reg     <= HST_HOLD;
          end
        end
        HST_HOLD: begin
          state_reg <= HST_IDLE;  // [RULE18]
        end
        default: begin
          state_reg <= HST_IDLE;
        end
      endcase
    end
  end

  // address and direction held through the extra hold clock
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mem_reg_q <= 1'b0;
      rd_reg    <= 1'b0;
      addr_reg  <= 16'h0000;
      wdata_reg <= 16'h0000;
    end else if ((state_reg == HST_IDLE) && cmd_valid && cmd_ready) begin
      mem_reg_q <= cmd_mem;  // [RULE14]
      rd_reg    <= bhi_dir_level(cmd_read, pol_sel);  // [RULE8]
      addr_reg  <= cmd_addr;
      wdata_reg <= cmd_wdata;
    end
  end

  assign cmd_ready            = (state_reg == HST_IDLE) & hif.transfer_enable_out_n;
  assign hif.select_n         = sel_n_reg;
  assign hif.data_strobe_in_n = strb_n_reg;
  assign hif.mem_reg          = mem_reg_q;
  assign hif.rd_wr            = rd_reg;
  assign hif.addr             = addr_reg;
  assign hif.data_h           = wdata_reg;
  assign hif.data_h_oe        = wr_oe_reg;
  assign rsp_valid            = rsp_valid_reg;
  assign rsp_rdata            = rdata_reg;
endmodule

/* testbench/bhi_asserts.sv */
// interface checker of the buffered host bus interface
`timescale 1ns/10ps
module bhi_asserts (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_b,
  // host pins
  input wire logic               select_n,
  input wire logic               data_strobe_in_n,
  input wire logic               mem_reg,
  input wire logic               rd_wr,
  input wire logic               address_latch_in,
  input wire bhi_pkg::bhi_word_t addr,
  input wire logic               data_d_oe,
  input wire logic               transfer_enable_out_n,
  input wire logic               ready_handshake_out_n,
  // straps
  input wire logic               polarity_sel,
  input wire logic               zero_wait,
  input wire logic               transparent_buffered,
  input wire logic               dma_request_or_width_pin
);
  import bhi_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // ****************************************************************
  // sequences
  // ****************************************************************
  sequence s_holdoff;
    ready_handshake_out_n[*3];
  endsequence
  sequence s_ready_fall;
    ##[1:2] $fell(ready_handshake_out_n);
  endsequence

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_te_needs_req: assert property ($fell(transfer_enable_out_n) |->
    $past(!select_n && !data_strobe_in_n)) else $error("enable fell without request");
  a_ready_delay: assert property ($fell(transfer_enable_out_n) |->
    s_holdoff ##0 s_ready_fall) else $error("ready delay after enable wrong");
  a_ready_in_te: assert property (!ready_handshake_out_n |->
    !transfer_enable_out_n) else $error("ready low outside transfer");
  a_release_tog: assert property ($rose(transfer_enable_out_n) |->
    $rose(ready_handshake_out_n)) else $error("enable and ready not released together");
  a_te_stands: assert property (!transfer_enable_out_n && ready_handshake_out_n |=>
    !transfer_enable_out_n) else $error("enable dropped before ready");
  a_read_drives: assert property ($fell(ready_handshake_out_n) &&
    (rd_wr == polarity_sel) |-> data_d_oe) else $error("read without data drive");
  a_write_quiet: assert property ($fell(ready_handshake_out_n) &&
    (rd_wr != polarity_sel) |-> !data_d_oe) else $error("write with data drive");
  a_idle_quiet: assert property (transfer_enable_out_n |->
    !data_d_oe) else $error("device drives bus outside transfer");
  a_straps_tied: assert property (zero_wait && !transparent_buffered &&
    dma_request_or_width_pin && address_latch_in) else $error("strap level wrong");
  a_ctl_steady: assert property (!transfer_enable_out_n && ready_handshake_out_n |->
    $stable(mem_reg) && $stable(rd_wr) && $stable(addr)) else $error("control moved in transfer");
  a_addr_hold: assert property ($rose(data_strobe_in_n) |->
    $stable(addr)) else $error("address not held at strobe release");
endmodule

/* testbench/bhi_tb_top.sv */
// testbench joining host and terminal ends of the host bus interface
`timescale 1ns/10ps
module buffered_host_bus_interface_tb_top;
  import bhi_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, async_inputs = 1'b0, pol_sel = 1'b1;
  logic eng_busy = 1'b0, eng_pending = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0;
  logic cmd_mem = 1'b1, cmd_ready, ram_we, ram_re, reg_we, reg_re, eng_hold, fast_access;
  logic rsp_valid, last_dir;
  logic [9:0] eng_hk_off = 10'h155;
  logic [5:0] reloc_base;
  bhi_word_t cmd_addr = 16'h0000, cmd_wdata = 16'h0000, rsp_rdata, hk_addr, rd;
  bhi_word_t ram_addr, ram_wdata, reg_addr, reg_wdata;
  bhi_word_t ram_rdata = 16'h0000, reg_rdata = 16'h0000;
  bhi_word_t mem [0:255];
  bhi_word_t rf [0:255];
  int err_total = 0, n_tests = 0, lat;

  always #5 clk_sys = ~clk_sys;

  // ****************************************************************
  // design ends and checker
  // ****************************************************************
  bhi_if i_bhi_if ();
  bhi_device i_bhi_device (.clk_sys(clk_sys), .rst_b(rst_b), .hif(i_bhi_if),
    .async_inputs(async_inputs), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .eng_busy(eng_busy), .eng_pending(eng_pending), .eng_hold(eng_hold),
    .eng_hk_off(eng_hk_off), .hk_addr(hk_addr), .reloc_base(reloc_base),
    .fast_access(fast_access));
  bhi_host i_bhi_host (.clk_sys(clk_sys), .rst_b(rst_b), .hif(i_bhi_if), .pol_sel(pol_sel),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_mem(cmd_mem),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  bhi_asserts i_bhi_asserts (.clk_sys(clk_sys), .rst_b(rst_b),
    .select_n(i_bhi_if.select_n), .data_strobe_in_n(i_bhi_if.data_strobe_in_n),
    .mem_reg(i_bhi_if.mem_reg), .rd_wr(i_bhi_if.rd_wr),
    .address_latch_in(i_bhi_if.address_latch_in), .addr(i_bhi_if.addr),
    .data_d_oe(i_bhi_if.data_d_oe), .transfer_enable_out_n(i_bhi_if.transfer_enable_out_n),
    .ready_handshake_out_n(i_bhi_if.ready_handshake_out_n),
    .polarity_sel(i_bhi_if.polarity_sel), .zero_wait(i_bhi_if.zero_wait),
    .transparent_buffered(i_bhi_if.transparent_buffered),
    .dma_request_or_width_pin(i_bhi_if.dma_request_or_width_pin));

  // internal ram and register file, read data the cycle after the strobe
  always @(posedge clk_sys) begin
    if (ram_we) mem[ram_addr[7:0]] <= ram_wdata;
    if (reg_we) rf[reg_addr[7:0]] <= reg_wdata;
    if (ram_re) ram_rdata <= mem[ram_addr[7:0]];
    if (reg_re) reg_rdata <= rf[reg_addr[7:0]];
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task chk(input string what, input bhi_word_t exp, input bhi_word_t got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task issue(input logic r, input logic m, input bhi_word_t a, input bhi_word_t w);
    @(posedge clk_sys);
    #1 cmd_valid = 1'b1;
    cmd_read = r;
    cmd_mem = m;
    cmd_addr = a;
    cmd_wdata = w;
    #1;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk_sys);
      #2;
    end
    @(posedge clk_sys);
    #1 cmd_valid = 1'b0;
  endtask

  task finish();
    int c, t0, t1;
    c = 0;
    t0 = -1;
    t1 = -1;
    do begin
      @(posedge clk_sys);
      #1 c++;
      if (i_bhi_if.transfer_enable_out_n === 1'b0 && t0 < 0) begin
        t0 = c;
        last_dir = i_bhi_if.rd_wr;
      end
      if (i_bhi_if.ready_handshake_out_n === 1'b0 && t1 < 0) t1 = c;
    end while (rsp_valid !== 1'b1 && c < 60);
    chk("response", 16'h0001, {15'h0000, rsp_valid});
    rd = rsp_rdata;
    lat = t1 - t0;
  endtask

  task op(input logic r, input logic m, input bhi_word_t a, input bhi_word_t w);
    issue(r, m, a, w);
    finish();
  endtask

  task t_reset();
    @(posedge clk_sys);
    #1 chk("enable idle", 16'h0001, {15'h0000, i_bhi_if.transfer_enable_out_n});
    chk("ready idle", 16'h0001, {15'h0000, i_bhi_if.ready_handshake_out_n});
    chk("hk base", 16'h0155, hk_addr);
    $display("test reset done");
  endtask

  task t_ram_pol(input logic p);
    pol_sel = p;
    op(1'b0, 1'b1, 16'h0012, {15'h52E1, p});
    chk("write dir", {15'h0000, ~p}, {15'h0000, last_dir});
    chk("write latency", 16'h0003, 16'(lat));
    op(1'b1, 1'b1, 16'h0012, 16'h0000);
    chk("read dir", {15'h0000, p}, {15'h0000, last_dir});
    chk("read data", {15'h52E1, p}, rd);
    $display("test ram polarity %0d done", p);
  endtask

  task t_regs();
    op(1'b0, 1'b0, 16'h0005, 16'h1234);
    op(1'b1, 1'b0, 16'h0005, 16'h0000);
    chk("reg data", 16'h1234, rd);
    op(1'b0, 1'b0, 16'h0030, 16'h006A);
    op(1'b1, 1'b0, 16'h0030, 16'h0000);
    chk("cfg read", 16'h006A, rd);
    chk("fast on", 16'h0001, {15'h0000, fast_access});
    chk("reloc base", 16'h002A, {10'h000, reloc_base});
    chk("hk moved", 16'hA955, hk_addr);
    $display("test registers done");
  endtask

  task t_contend(input logic pend, input logic busy, input logic blk);
    eng_pending = pend;
    eng_busy = busy;
    issue(1'b1, 1'b1, 16'h0012, 16'h0000);
    repeat (3) @(posedge clk_sys);
    #1 chk("held off", {15'h0, blk}, {15'h0, i_bhi_if.transfer_enable_out_n});
    chk("engine hold", {15'h0, ~blk}, {15'h0, eng_hold});
    @(posedge clk_sys);
    #1 eng_pending = 1'b0;
    eng_busy = 1'b0;
    finish();
    chk("contend data", 16'hA5C2, rd);
    $display("test contention %0d%0d done", pend, busy);
  endtask

  task t_async();
    async_inputs = 1'b1;
    op(1'b1, 1'b1, 16'h0012, 16'h0000);
    chk("async latency", 16'h0004, 16'(lat));
    chk("async data", 16'hA5C2, rd);
    $display("test async done");
  endtask

  task stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    t_reset();
    t_ram_pol(1'b1);
    t_ram_pol(1'b0);
    t_contend(1'b0, 1'b1, 1'b1);
    t_contend(1'b1, 1'b0, 1'b1);
    t_regs();
    t_contend(1'b1, 1'b0, 1'b0);
    t_async();
    stop_test();
  end

  initial begin
    #20000;
    err_total++;
    stop_test();
  end
endmodule
